//--- hdl/pom_top.sv
// holds: port override mux top, first-port registers and second-port pin drive
// assumes: register master per plain strobe protocol, pins synchronous to clock
//
// The plain strobed port is this design's own decision.
`default_nettype none

// Functional notes
// - pin 3 direction override on when receiver enabled; value is comparator enable
// - pin 3 input override from pin-change mask with group enable, or analog disable
// - pin 2 input override from pin-change mask with group enable, or analog disable
// - clock-out option drives system clock on pin 1 regardless of registers
// - clock-out option is active when its configuration bit reads zero
// - pin 1 direction override from clock out, remapped compare A, or clock master
// - pin 1 input override from pin-change, irq zero or analog disable
// - pin 0 has only the input override, from pin-change or analog disable
// - all four second-port pin inputs feed pin-change group 1
// - first-port input register at 0x00 reads pin levels
// - first-port direction register at 0x01, reset 0x00
// - first-port output data register at 0x02, reset zero
module pom_top
    import pom_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe_n,
    input wire logic clock_fuse_bit,
    input wire pom_periph_s periph,
    input wire logic [3:0] port_b_data,
    input wire logic [3:0] port_b_dir,
    input wire logic [3:0] port_b_pullup,
    input wire logic [3:0] port_b_in,
    output logic [3:0] port_b_out,
    output logic [3:0] port_b_oe_n,
    output logic [3:0] port_b_pullup_on,
    output logic [3:0] port_b_input_enable,
    output logic [3:0] pinchange_group1_src,
    output logic [3:0] port_b_digital_in,
    output logic system_clock_pin_out
);

    // ************************************************************
    // state
    // ************************************************************
    pom_state_s state;
    pom_state_s next_state;
    pom_ovr_s ovr [4];
    logic clock_output_option;

    assign clock_output_option = (clock_fuse_bit == POM_FUSE_PROGRAMMED);

    pom_pin_ovr u_pin_ovr (
        .periph(periph),
        .clock_output_option(clock_output_option),
        .ovr(ovr)
    );

    // ************************************************************
    // register file
    // ************************************************************
    always_comb
    begin
        next_state = state;
        next_state.rdata = POM_RD_UNMAPPED;
        if (wr)
        begin
            unique case (addr)
                POM_OFS_DIRECTION: next_state.direction = wdata;
                POM_OFS_OUTPUT_DATA: next_state.output_data = wdata;
                default: ;
            endcase
        end
        if (rd)
        begin
            unique case (addr)
                POM_OFS_PIN_LEVELS: next_state.rdata = port_a_in;
                POM_OFS_DIRECTION: next_state.rdata = state.direction;
                POM_OFS_OUTPUT_DATA: next_state.rdata = state.output_data;
                default: next_state.rdata = POM_RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state.direction <= POM_RST_DIRECTION;
            state.output_data <= POM_RST_OUTPUT_DATA;
            state.rdata <= POM_RD_UNMAPPED;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;
    assign port_a_out = state.output_data;
    assign port_a_oe_n = ~state.direction;

    // ************************************************************
    // second-port pin drive
    // ************************************************************
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            port_b_out[i] = ovr[i].value_override_enable ? ovr[i].value_override_value : port_b_data[i];
            port_b_oe_n[i] = ~(ovr[i].direction_override_enable ? ovr[i].direction_override_value
                                                                 : port_b_dir[i]);
            port_b_pullup_on[i] = ovr[i].pullup_override_enable ? 1'b0 : port_b_pullup[i];
            port_b_input_enable[i] = ovr[i].input_enable_override_enable
                ? ovr[i].input_enable_override_value : 1'b1;
            port_b_digital_in[i] = port_b_in[i] & port_b_input_enable[i];
        end
        // pin 1 clock out carries the system clock itself
        if (clock_output_option)
        begin
            port_b_out[1] = clock;
        end
    end

    assign system_clock_pin_out = clock_output_option & clock;
    assign pinchange_group1_src = port_b_in;

    // ************************************************************
    // checks
    // ************************************************************
    a_dir_write: assert property (@(posedge clock) disable iff (rst)
        wr && addr == POM_OFS_DIRECTION |=> port_a_oe_n == ~$past(wdata)) else $error("direction write");
    a_rd_latency: assert property (@(posedge clock) disable iff (rst)
        rd && addr == POM_OFS_DIRECTION && !wr |=> rdata == $past(state.direction)) else $error("read lat");
    a_out_write: assert property (@(posedge clock) disable iff (rst)
        wr && addr == POM_OFS_OUTPUT_DATA |=> port_a_out == $past(wdata)) else $error("out write");
    a_pin_read: assert property (@(posedge clock) disable iff (rst)
        rd && addr == POM_OFS_PIN_LEVELS |=> rdata == $past(port_a_in)) else $error("pin read");
    a_tx_drive: assert property (@(posedge clock) disable iff (rst)
        periph.serial_tx_enable |-> !port_b_oe_n[2] && port_b_out[2] == periph.serial_tx_bit)
        else $error("tx drive");
    a_cmp_drive: assert property (@(posedge clock) disable iff (rst)
        periph.comparator_out_enable |-> port_b_out[3] == periph.comparator_result) else $error("cmp");
    a_rx_dir: assert property (@(posedge clock) disable iff (rst)
        periph.serial_rx_enable |-> port_b_oe_n[3] == !periph.comparator_out_enable) else $error("rx dir");
    a_clk_dir: assert property (@(posedge clock) disable iff (rst)
        clock_fuse_bit == POM_FUSE_PROGRAMMED |-> !port_b_oe_n[1]) else $error("clk dir");
    a_pc_src: assert property (@(posedge clock) disable iff (rst)
        pinchange_group1_src == port_b_in) else $error("pc src");
    a_pin0_plain: assert property (@(posedge clock) disable iff (rst)
        port_b_out[0] == port_b_data[0] && port_b_oe_n[0] == !port_b_dir[0]) else $error("pin0");

endmodule : pom_top

`default_nettype wire

//--- hdl/pom_pkg.sv
// package: offsets, reset values and carrier structs of the port override mux
// assumes: single 40 MHz clock domain, asynchronous active-high reset
`default_nettype none

package pom_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [1:0] POM_OFS_PIN_LEVELS = 2'h0;
    localparam logic [1:0] POM_OFS_DIRECTION = 2'h1;
    localparam logic [1:0] POM_OFS_OUTPUT_DATA = 2'h2;
    localparam logic [7:0] POM_RST_DIRECTION = 8'h00;
    localparam logic [7:0] POM_RST_OUTPUT_DATA = 8'h00;
    localparam logic [7:0] POM_RD_UNMAPPED = 8'h00;
    localparam logic POM_FUSE_PROGRAMMED = 1'h0;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic pullup_override_enable;
        logic direction_override_enable;
        logic direction_override_value;
        logic value_override_enable;
        logic value_override_value;
        logic input_enable_override_enable;
        logic input_enable_override_value;
    } pom_ovr_s;

    typedef struct packed {
        logic comparator_out_enable;
        logic comparator_result;
        logic serial_rx_enable;
        logic serial_tx_enable;
        logic serial_tx_bit;
        logic serial_clock_master;
        logic compare_a_enable;
        logic compare_a_output;
        logic timer_pin_a;
        logic pinchange_group1_enable;
        logic [3:0] pinchange_mask;
        logic external_irq_zero;
        logic [3:0] analog_digital_disable;
    } pom_periph_s;

    typedef struct packed {
        logic [7:0] direction;
        logic [7:0] output_data;
        logic [7:0] rdata;
    } pom_state_s;

endpackage : pom_pkg

`default_nettype wire

//--- hdl/pom_pin_ovr.sv
// holds: per-pin override equations of the four second-port pins
// assumes: peripheral enables are synchronous levels from their units
`default_nettype none

module pom_pin_ovr
    import pom_pkg::*;
(
    input wire pom_periph_s periph,
    input wire logic clock_output_option,
    output var pom_ovr_s ovr [4]
);

    logic [3:0] pc;
    logic [3:0] die;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            pc[i] = periph.pinchange_mask[i] & periph.pinchange_group1_enable;
            die[i] = pc[i] | periph.analog_digital_disable[i];
        end
        // pin 0: input override only
        ovr[0] = '0;
        ovr[0].input_enable_override_enable = die[0];
        ovr[0].input_enable_override_value = pc[0];
        // pin 1: clock out, compare A, serial clock, irq 0
        ovr[1] = '0;
        ovr[1].pullup_override_enable = clock_output_option;
        ovr[1].direction_override_enable = clock_output_option
            | (periph.compare_a_enable & periph.timer_pin_a)
            | periph.serial_clock_master;
        ovr[1].direction_override_value = clock_output_option
            | (periph.compare_a_enable & periph.timer_pin_a & periph.compare_a_output);
        ovr[1].value_override_enable = clock_output_option;
        ovr[1].input_enable_override_enable = die[1] | periph.external_irq_zero;
        ovr[1].input_enable_override_value = pc[1] | periph.external_irq_zero;
        // pin 2: serial transmitter
        ovr[2] = '0;
        ovr[2].pullup_override_enable = periph.serial_tx_enable;
        ovr[2].direction_override_enable = periph.serial_tx_enable;
        ovr[2].direction_override_value = periph.serial_tx_enable;
        ovr[2].value_override_enable = periph.serial_tx_enable;
        ovr[2].value_override_value = periph.serial_tx_enable & periph.serial_tx_bit;
        ovr[2].input_enable_override_enable = die[2];
        ovr[2].input_enable_override_value = pc[2];
        // pin 3: comparator output, serial receiver
        ovr[3] = '0;
        ovr[3].pullup_override_enable = periph.comparator_out_enable;
        ovr[3].direction_override_enable = periph.serial_rx_enable;
        ovr[3].direction_override_value = periph.comparator_out_enable;
        ovr[3].value_override_enable = periph.comparator_out_enable;
        ovr[3].value_override_value = periph.comparator_result & periph.comparator_out_enable;
        ovr[3].input_enable_override_enable = die[3];
        ovr[3].input_enable_override_value = pc[3];
    end

endmodule : pom_pin_ovr

`default_nettype wire

//--- test/pom_pins_model.sv
// holds: board-side pin model of both ports
// assumes: a released pin is pulled to the level the bench sets for it
`default_nettype none

module pom_pins_model
(
    input wire logic [7:0] a_out,
    input wire logic [7:0] a_oe_n,
    input wire logic [7:0] a_ext,
    output logic [7:0] a_in,
    input wire logic [3:0] b_out,
    input wire logic [3:0] b_oe_n,
    input wire logic [3:0] b_ext,
    output logic [3:0] b_in
);
    // a driven pin shows its own drive, a released one the board level
    assign a_in = (a_oe_n & a_ext) | (~a_oe_n & a_out);
    assign b_in = (b_oe_n & b_ext) | (~b_oe_n & b_out);
endmodule : pom_pins_model

`default_nettype wire

//--- test/port_override_mux_test.sv
// holds: self-checking bench of the port override mux
// assumes: pom_pkg, pom_top and pom_pins_model are compiled first
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module port_override_mux_test;
    import pom_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, fuse = 1'h1, clk_pin;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, a_ext = 8'h0F, rdata, a_in, a_out, a_oe_n;
    logic [3:0] b_data = 4'h0, b_dir = 4'h0, b_pu = 4'hF, b_ext = 4'h6;
    logic [3:0] b_in, b_out, b_oe_n, b_pu_on, b_ie, b_src, b_din;
    pom_periph_s p = '0;
    int bad_count = 0, tests_run = 0, cyc = 0;

    pom_top dut_u (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .port_a_in(a_in), .port_a_out(a_out), .port_a_oe_n(a_oe_n), .clock_fuse_bit(fuse), .periph(p),
        .port_b_data(b_data), .port_b_dir(b_dir), .port_b_pullup(b_pu), .port_b_in(b_in), .port_b_out(b_out),
        .port_b_oe_n(b_oe_n), .port_b_pullup_on(b_pu_on), .port_b_input_enable(b_ie),
        .pinchange_group1_src(b_src), .port_b_digital_in(b_din), .system_clock_pin_out(clk_pin));
    pom_pins_model pins_u (.a_out(a_out), .a_oe_n(a_oe_n), .a_ext(a_ext), .a_in(a_in),
        .b_out(b_out), .b_oe_n(b_oe_n), .b_ext(b_ext), .b_in(b_in));

    always #12.5 clock = ~clock;

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end

    task reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'h0;
    endtask : reg_wr

    task reg_chk(input logic [1:0] a, input logic [7:0] e);
        @(posedge clock);
        rd <= 1'h1;
        addr <= a;
        @(posedge clock);
        rd <= 1'h0;
        #1;
        `CHK(rdata, e)
    endtask : reg_chk

    task t_regs;
        reg_chk(2'h1, POM_RST_DIRECTION);
        reg_chk(2'h2, POM_RST_OUTPUT_DATA);
        `CHK(a_oe_n, 8'hFF)
        reg_wr(2'h1, 8'hA5);
        reg_wr(2'h2, 8'h3C);
        reg_wr(2'h0, 8'hFF);
        `CHK(a_oe_n, 8'h5A)
        `CHK(a_out, 8'h3C)
        reg_chk(2'h1, 8'hA5);
        reg_chk(2'h2, 8'h3C);
        reg_chk(2'h0, (8'hA5 & 8'h3C) | (8'h5A & 8'h0F));
        reg_chk(2'h3, POM_RD_UNMAPPED);
        $display("register test done");
    endtask : t_regs

    task t_outputs;
        @(posedge clock);
        b_dir <= 4'hF;
        b_data <= 4'h5;
        p.serial_rx_enable <= 1'h1;
        #1;
        `CHK(b_oe_n[3], 1'h1)
        `CHK({b_pu_on[0], b_oe_n[0], b_out[0]}, 3'h5)
        @(posedge clock);
        b_dir <= 4'h0;
        p.comparator_out_enable <= 1'h1;
        p.comparator_result <= 1'h1;
        p.serial_tx_enable <= 1'h1;
        p.serial_tx_bit <= 1'h1;
        #1;
        `CHK({b_oe_n[3], b_out[3], b_pu_on[3]}, 3'h2)
        `CHK({b_oe_n[2], b_out[2], b_pu_on[2]}, 3'h2)
        @(posedge clock);
        p.comparator_result <= 1'h0;
        p.serial_tx_bit <= 1'h0;
        #1;
        `CHK({b_out[3], b_out[2], b_oe_n[0]}, 3'h1)
        $display("pin drive test done");
    endtask : t_outputs

    task t_pin1;
        @(posedge clock);
        b_dir <= 4'hF;
        p.timer_pin_a <= 1'h1;
        p.compare_a_enable <= 1'h1;
        p.compare_a_output <= 1'h1;
        #1;
        `CHK(b_oe_n[1], 1'h0)
        @(posedge clock);
        p.compare_a_output <= 1'h0;
        #1;
        `CHK(b_oe_n[1], 1'h1)
        @(posedge clock);
        p.compare_a_enable <= 1'h0;
        p.serial_clock_master <= 1'h1;
        #1;
        `CHK(b_oe_n[1], 1'h1)
        `CHK(b_out[1], b_data[1])
        @(posedge clock);
        fuse <= POM_FUSE_PROGRAMMED;
        #1;
        `CHK({b_out[1], clk_pin}, 2'h3)
        @(negedge clock);
        #1;
        `CHK({b_out[1], clk_pin}, 2'h0)
        $display("pin one test done");
    endtask : t_pin1

    task t_inputs;
        @(posedge clock);
        p <= '0;
        fuse <= 1'h1;
        b_dir <= 4'h0;
        @(posedge clock);
        p.analog_digital_disable <= 4'hF;
        p.pinchange_mask <= 4'hF;
        #1;
        `CHK(b_ie, 4'h0)
        `CHK(b_src, 4'h6)
        @(posedge clock);
        p.external_irq_zero <= 1'h1;
        #1;
        `CHK(b_ie, 4'h2)
        @(posedge clock);
        p.external_irq_zero <= 1'h0;
        p.pinchange_group1_enable <= 1'h1;
        #1;
        `CHK(b_ie, 4'hF)
        $display("input override test done");
    endtask : t_inputs

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'h0;
        t_regs();
        t_outputs();
        t_pin1();
        t_inputs();
        tally_and_finish();
    end
endmodule : port_override_mux_test

`default_nettype wire
